/* File: core/pclsb_pkg.sv */
// Shared constants, register map and carrier types for the local sideband block.
package pclsb_pkg;

    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 32;

    // Register byte offsets.
    localparam logic [7:0] OFS_COMMAND   = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_CACHE     = 8'h08;
    localparam logic [7:0] OFS_CONTROL   = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h14;

    // Command register layout.
    localparam int unsigned CMD_W         = 11;
    localparam int unsigned CMD_MIRROR_W  = 10;
    localparam int unsigned CMD_RSVD_POS  = 7;
    localparam int unsigned CMD_IRQDIS_POS = 10;
    localparam logic [10:0] CMD_RESET     = 11'h000;
    localparam logic [10:0] CMD_WR_MASK   = 11'h77F;

    // Status register layout: six sticky error flags.
    localparam int unsigned STAT_W        = 6;
    localparam logic [5:0]  STAT_RESET    = 6'h00;

    // Cache line size register.
    localparam int unsigned CACHE_W       = 8;
    localparam logic [7:0]  CACHE_RESET   = 8'h00;

    // Control register: bit 0 selects the 64-bit local bus.
    localparam int unsigned CTRL_WIDE_POS = 0;
    localparam logic [0:0]  CTRL_RESET    = 1'h0;

    // Interrupt status and mask layout.
    localparam int unsigned IRQ_W         = 4;
    localparam int unsigned IRQ_LOCAL_POS = 0;
    localparam int unsigned IRQ_ABORT_POS = 1;
    localparam int unsigned IRQ_DISC_POS  = 2;
    localparam int unsigned IRQ_RETRY_POS = 3;
    localparam logic [3:0]  IRQ_RESET     = 4'h0;

    // Configuration header range held inside the core.
    localparam logic [7:0]  CFG_HDR_LAST  = 8'h3F;

    // Bus command encodings used by the target decode.
    localparam logic [3:0]  BUS_CMD_SPECIAL = 4'h1;

    // Synchroniser depth for pin inputs.
    localparam int unsigned SYNC_STAGES   = 3;

    // Master-side transfer information from the PCI engine.
    typedef struct packed {
        logic       data_xfer;
        logic       wide_trans;
    } pclsb_master_s;

    // Target-side transaction information from the PCI engine.
    typedef struct packed {
        logic       start;
        logic [3:0] bus_cmd;
        logic       active;
        logic       data_xfer;
        logic [5:0] bar_hit;
        logic       exprom_hit;
        logic       cfg_access;
        logic [7:0] cfg_offset;
    } pclsb_target_s;

    // Termination and pacing requests back to the PCI engine.
    typedef struct packed {
        logic       abort;
        logic       disconnect;
        logic       retry;
        logic       ready;
    } pclsb_term_s;

endpackage : pclsb_pkg

/* File: core/pclsb_sync.sv */
// Three-stage input synchroniser with a two-stage agreement filter.
`timescale 1ns/1ps
`default_nettype none

module pclsb_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic async_in,
    output var  logic sync_out
);

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic out_r;

    // The first stage feeds only the second; the output moves once stages two and three agree.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_r  <= RESET_VAL;
            s2_r  <= RESET_VAL;
            s3_r  <= RESET_VAL;
            out_r <= RESET_VAL;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                out_r <= s3_r;
            end
        end
    end

    assign sync_out = out_r;

endmodule // pclsb_sync

`default_nettype wire

/* File: core/pclsb_local_if.sv */
// Local sideband interface of the PCI core: strobes, mirrors, interrupt and target controls.
// Operation
// - Drive active-low upper-DWORD master strobe when local bus is 64 bits.
// - Hold active-low wide indication while master transaction uses 64-bit transfers.
// - Local interrupt request asserts INTA only when interrupts are enabled.
// - Present eight-bit cache line size continuously on a local output.
// - Mirror command bits 0 to 9 in place on a ten-bit output.
// - Present status bits 8,11,12,13,14,15 as bits 0 to 5.
// - Local abort request makes the core end the transaction with target abort.
// - Local early end request yields disconnect, or retry when no data moved.
// - Target direction output is high for read, low for write.
// - Access window active on any region hit, capability hit or special cycle.
// - A strobe marks consumed or valid data; back-end advances next clock.
// - Raise extended capability hit for configuration offsets above the header.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module pclsb_local_if #(
    parameter int unsigned SYNC_STAGES = pclsb_pkg::SYNC_STAGES
) (
    input  wire logic                      core_clk,
    input  wire logic                      reset_n,
    // Register port.
    input  wire logic [7:0]                reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output var  logic [31:0]               reg_rdata,
    output var  logic                      irq,
    // PCI engine side.
    input  wire pclsb_pkg::pclsb_master_s  eng_master,
    input  wire pclsb_pkg::pclsb_target_s  eng_target,
    input  wire logic [5:0]                eng_status_set,
    output var  pclsb_pkg::pclsb_term_s    eng_term,
    output var  logic [3:0]                eng_upper_be_n,
    output var  logic                      inta_out,
    output var  logic                      inta_oe,
    // Local master side.
    input  wire logic [3:0]                master_byte_lane_enables_n,
    output var  logic                      master_word_strobe_n,
    output var  logic                      master_upper_dword_strobe_n,
    output var  logic                      master_wide_transfer_n,
    // Local interrupt and configuration mirrors.
    input  wire logic                      local_irq_n,
    output var  logic [7:0]                cache_line_size,
    output var  logic [9:0]                command_mirror,
    output var  logic [5:0]                status_mirror,
    // Local target side.
    input  wire logic                      target_abort_request_n,
    input  wire logic                      target_early_end_request_n,
    input  wire logic                      target_ready_n,
    output var  logic                      target_read_not_write,
    output var  logic                      target_access_window_n,
    output var  logic [3:0]                target_latched_bus_command,
    output var  logic                      extended_cap_hit
);

    // Software-visible state.
    logic [pclsb_pkg::CMD_W-1:0]   command_r;
    logic [pclsb_pkg::STAT_W-1:0]  status_r;
    logic [pclsb_pkg::STAT_W-1:0]  status_nxt;
    logic [pclsb_pkg::CACHE_W-1:0] cache_r;
    logic                          wide_bus_r;
    logic [pclsb_pkg::IRQ_W-1:0]   irq_stat_r;
    logic [pclsb_pkg::IRQ_W-1:0]   irq_stat_nxt;
    logic [pclsb_pkg::IRQ_W-1:0]   irq_mask_r;
    logic [31:0]                   rdata_r;
    logic                          irq_r;

    // Transaction tracking.
    logic                          data_moved_r;
    logic                          term_abort_r;
    logic                          term_disc_r;
    logic                          term_retry_r;
    logic                          term_ready_r;
    logic                          local_irq_sync_n;
    logic                          local_irq_prev_n_r;

    // Registered local outputs.
    logic                          m_strobe_n_r;
    logic                          m_upper_strobe_n_r;
    logic                          m_wide_n_r;
    logic [3:0]                    upper_be_n_r;
    logic                          inta_r;
    logic                          t_rnw_r;
    logic                          t_access_n_r;
    logic [3:0]                    t_cmd_r;
    logic                          cap_hit_r;

    // Address decode.
    wire sel_command = (reg_addr == pclsb_pkg::OFS_COMMAND);
    wire sel_status  = (reg_addr == pclsb_pkg::OFS_STATUS);
    wire sel_cache   = (reg_addr == pclsb_pkg::OFS_CACHE);
    wire sel_control = (reg_addr == pclsb_pkg::OFS_CONTROL);
    wire sel_istat   = (reg_addr == pclsb_pkg::OFS_IRQ_STAT);
    wire sel_imask   = (reg_addr == pclsb_pkg::OFS_IRQ_MASK);

    wire wr_command  = reg_wr && sel_command;
    wire wr_status   = reg_wr && sel_status;
    wire wr_cache    = reg_wr && sel_cache;
    wire wr_control  = reg_wr && sel_control;
    wire wr_istat    = reg_wr && sel_istat;
    wire wr_imask    = reg_wr && sel_imask;

    wire [31:0] rd_mux =
        sel_command ? {21'h0, command_r} :
        sel_status  ? {26'h0, status_r} :
        sel_cache   ? {24'h000000, cache_r} :
        sel_control ? {31'h0, wide_bus_r} :
        sel_istat   ? {28'h0000000, irq_stat_r} :
        sel_imask   ? {28'h0000000, irq_mask_r} :
        32'h00000000;

    // Target decode.
    wire special_cycle = (t_cmd_r == pclsb_pkg::BUS_CMD_SPECIAL);
    wire cfg_beyond_hdr = eng_target.cfg_access &&
                          (eng_target.cfg_offset > pclsb_pkg::CFG_HDR_LAST);
    wire any_hit = (|eng_target.bar_hit) || eng_target.exprom_hit || cap_hit_r;
    wire access_now = eng_target.active && (any_hit || special_cycle);
    wire cmd_is_read = ~eng_target.bus_cmd[0];

    // Termination requests from the local target.
    wire abort_req = eng_target.active && !target_abort_request_n;
    wire early_req = eng_target.active && !target_early_end_request_n && !abort_req;
    wire moved_now = data_moved_r || eng_target.data_xfer;

    // Interrupt gating and events.
    wire irq_enabled = ~command_r[pclsb_pkg::CMD_IRQDIS_POS];
    wire local_irq_rise = local_irq_prev_n_r && !local_irq_sync_n;
    wire [pclsb_pkg::IRQ_W-1:0] irq_events = {
        early_req && !moved_now,
        early_req && moved_now,
        abort_req,
        local_irq_rise
    };

    // Sticky flags: a set in the same cycle as a write-one clear wins.
    always_comb begin
        status_nxt   = status_r;
        irq_stat_nxt = irq_stat_r;
        if (wr_status) begin
            status_nxt = status_nxt & ~reg_wdata[pclsb_pkg::STAT_W-1:0];
        end
        if (wr_istat) begin
            irq_stat_nxt = irq_stat_nxt & ~reg_wdata[pclsb_pkg::IRQ_W-1:0];
        end
        status_nxt   = status_nxt | eng_status_set;
        irq_stat_nxt = irq_stat_nxt | irq_events;
    end

    // The local interrupt pin comes from outside logic of unknown timing.
    pclsb_sync #(
        .RESET_VAL (1'b1)
    ) u_irq_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .async_in (local_irq_n),
        .sync_out (local_irq_sync_n)
    );

    // Register file.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            command_r  <= pclsb_pkg::CMD_RESET;
            cache_r    <= pclsb_pkg::CACHE_RESET;
            wide_bus_r <= pclsb_pkg::CTRL_RESET;
            irq_mask_r <= pclsb_pkg::IRQ_RESET;
        end else begin
            if (wr_command) begin
                command_r <= reg_wdata[pclsb_pkg::CMD_W-1:0] & pclsb_pkg::CMD_WR_MASK;
            end
            if (wr_cache) begin
                cache_r <= reg_wdata[pclsb_pkg::CACHE_W-1:0];
            end
            if (wr_control) begin
                wide_bus_r <= reg_wdata[pclsb_pkg::CTRL_WIDE_POS];
            end
            if (wr_imask) begin
                irq_mask_r <= reg_wdata[pclsb_pkg::IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_r   <= pclsb_pkg::STAT_RESET;
            irq_stat_r <= pclsb_pkg::IRQ_RESET;
            rdata_r    <= 32'h00000000;
            irq_r      <= 1'b0;
        end else begin
            status_r   <= status_nxt;
            irq_stat_r <= irq_stat_nxt;
            rdata_r    <= reg_rd ? rd_mux : 32'h00000000;
            irq_r      <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    // Master strobes follow the engine one clock later so that they leave a flop.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            m_strobe_n_r       <= 1'b1;
            m_upper_strobe_n_r <= 1'b1;
            m_wide_n_r         <= 1'b1;
            upper_be_n_r       <= 4'hF;
        end else begin
            m_strobe_n_r       <= ~eng_master.data_xfer;
            m_upper_strobe_n_r <= ~(eng_master.data_xfer && eng_master.wide_trans
                                    && wide_bus_r);
            m_wide_n_r         <= ~eng_master.wide_trans;
            upper_be_n_r       <= wide_bus_r ? master_byte_lane_enables_n : 4'hF;
        end
    end

    // Interrupt pin: open drain, driven low only while enabled and requested.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            inta_r             <= 1'b0;
            local_irq_prev_n_r <= 1'b1;
        end else begin
            inta_r             <= !local_irq_sync_n && irq_enabled;
            local_irq_prev_n_r <= local_irq_sync_n;
        end
    end

    // Target command latch, direction, access window and capability hit.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            t_cmd_r      <= 4'h0;
            t_rnw_r      <= 1'b0;
            t_access_n_r <= 1'b1;
            cap_hit_r    <= 1'b0;
        end else begin
            if (eng_target.start) begin
                t_cmd_r <= eng_target.bus_cmd;
                t_rnw_r <= cmd_is_read;
            end
            t_access_n_r <= ~access_now;
            cap_hit_r    <= cfg_beyond_hdr;
        end
    end

    // Termination: abort outranks an early end; retry only when nothing moved yet.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_moved_r <= 1'b0;
            term_abort_r <= 1'b0;
            term_disc_r  <= 1'b0;
            term_retry_r <= 1'b0;
            term_ready_r <= 1'b0;
        end else begin
            if (eng_target.start) begin
                data_moved_r <= 1'b0;
            end else if (eng_target.data_xfer) begin
                data_moved_r <= 1'b1;
            end
            term_abort_r <= abort_req;
            term_disc_r  <= early_req && moved_now;
            term_retry_r <= early_req && !moved_now;
            term_ready_r <= eng_target.active && !target_ready_n;
        end
    end

    // Output wiring; every value here except the constant inta_out leaves a flop.
    assign reg_rdata                   = rdata_r;
    assign irq                         = irq_r;
    assign eng_term.abort              = term_abort_r;
    assign eng_term.disconnect         = term_disc_r;
    assign eng_term.retry              = term_retry_r;
    assign eng_term.ready              = term_ready_r;
    assign eng_upper_be_n              = upper_be_n_r;
    assign inta_out                    = 1'b0;
    assign inta_oe                     = inta_r;
    assign master_word_strobe_n        = m_strobe_n_r;
    assign master_upper_dword_strobe_n = m_upper_strobe_n_r;
    assign master_wide_transfer_n      = m_wide_n_r;
    assign cache_line_size             = cache_r;
    assign command_mirror              = command_r[pclsb_pkg::CMD_MIRROR_W-1:0];
    assign status_mirror               = status_r;
    assign target_read_not_write       = t_rnw_r;
    assign target_access_window_n      = t_access_n_r;
    assign target_latched_bus_command  = t_cmd_r;
    assign extended_cap_hit            = cap_hit_r;

endmodule // pclsb_local_if

`default_nettype wire

/* File: dv/pclsb_local_if_checker.sv */
// Port assertions for the local sideband block.
`timescale 1ns/1ps
`default_nettype none
module pclsb_local_if_checker (
    input wire logic                     core_clk,
    input wire logic                     reset_n,
    input wire pclsb_pkg::pclsb_master_s eng_master,
    input wire pclsb_pkg::pclsb_target_s eng_target,
    input wire pclsb_pkg::pclsb_term_s   eng_term,
    input wire logic                     master_word_strobe_n,
    input wire logic                     master_upper_dword_strobe_n,
    input wire logic                     master_wide_transfer_n,
    input wire logic                     target_abort_request_n,
    input wire logic                     target_early_end_request_n,
    input wire logic                     target_ready_n,
    input wire logic                     target_read_not_write,
    input wire logic                     target_access_window_n,
    input wire logic [3:0]               target_latched_bus_command,
    input wire logic                     extended_cap_hit
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    chk_word_strobe: assert property (master_word_strobe_n == !$past(eng_master.data_xfer))
        else $error("word strobe does not follow the data phase");
    chk_upper_pair: assert property (!master_upper_dword_strobe_n |-> !master_word_strobe_n)
        else $error("upper strobe without lower strobe");
    chk_wide_flag: assert property (master_wide_transfer_n == !$past(eng_master.wide_trans))
        else $error("wide indication does not follow the engine");
    chk_cmd_latch: assert property (eng_target.start |=>
        target_latched_bus_command == $past(eng_target.bus_cmd)
        && target_read_not_write == !$past(eng_target.bus_cmd[0]))
        else $error("command or direction not latched at start");
    chk_cmd_hold: assert property (!eng_target.start |=> $stable(target_latched_bus_command))
        else $error("latched command moved without start");
    chk_window_hit: assert property (eng_target.active
        && (|eng_target.bar_hit || eng_target.exprom_hit) |=> !target_access_window_n)
        else $error("access window closed during a hit");
    chk_cap_hit: assert property (extended_cap_hit
        == ($past(eng_target.cfg_access) && $past(eng_target.cfg_offset) > 8'h3F))
        else $error("capability hit wrong for offset");
    chk_abort_term: assert property (eng_target.active && !target_abort_request_n |=>
        eng_term.abort && !eng_term.disconnect && !eng_term.retry)
        else $error("abort request not honoured");
    chk_early_end: assert property (eng_term.retry || eng_term.disconnect |->
        !$past(target_early_end_request_n) && $past(target_abort_request_n))
        else $error("early end without request");
    chk_ready_gate: assert property (eng_term.ready |->
        !$past(target_ready_n) && $past(eng_target.active))
        else $error("ready passed while back-end not ready");
    cov_retry: cover property (eng_term.retry);
    cov_disc: cover property (eng_term.disconnect);
    cov_abort: cover property (eng_term.abort);
    cov_upper: cover property (!master_upper_dword_strobe_n);
endmodule // pclsb_local_if_checker
bind pclsb_local_if pclsb_local_if_checker u_chk (.core_clk, .reset_n, .eng_master,
    .eng_target, .eng_term, .master_word_strobe_n, .master_upper_dword_strobe_n,
    .master_wide_transfer_n, .target_abort_request_n, .target_early_end_request_n,
    .target_ready_n, .target_read_not_write, .target_access_window_n,
    .target_latched_bus_command, .extended_cap_hit);
`default_nettype wire

/* File: dv/pclsb_backend.sv */
// Behavioural back-end model for the local master and target sides.
`timescale 1ns/1ps
`default_nettype none
module pclsb_backend (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       target_access_window_n,
    input  wire logic       master_upper_dword_strobe_n,
    input  wire logic       slow,
    input  wire logic [1:0] req_mode,
    input  wire logic       irq_req,
    output var  logic [3:0] master_byte_lane_enables_n,
    output var  logic       local_irq_n,
    output var  logic       target_abort_request_n,
    output var  logic       target_early_end_request_n,
    output var  logic       target_ready_n
);
    logic [1:0] wait_r;
    assign local_irq_n = !irq_req;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            master_byte_lane_enables_n <= 4'hF;
            wait_r <= 2'h0;
            target_ready_n <= 1'b1;
            target_abort_request_n <= 1'b1;
            target_early_end_request_n <= 1'b1;
        end else begin
            // Lanes step on each consumed upper word so a stale value shows up.
            if (!master_upper_dword_strobe_n) begin
                master_byte_lane_enables_n <= master_byte_lane_enables_n - 4'h1;
            end
            wait_r <= target_access_window_n ? 2'h0 : wait_r + {1'b0, wait_r != 2'h3};
            target_ready_n <= target_access_window_n || (slow && wait_r != 2'h3);
            target_abort_request_n <= target_access_window_n || req_mode != 2'h2;
            target_early_end_request_n <= target_access_window_n || req_mode != 2'h1;
        end
    end
endmodule // pclsb_backend
`default_nettype wire

/* File: dv/pclsb_local_if_bench.sv */
// Self-checking bench for the local sideband block.
`timescale 1ns/1ps
`default_nettype none
module pclsb_local_if_bench;
    logic core_clk, reset_n, reg_wr, reg_rd, slow, irq_req, irq, inta_out, inta_oe;
    logic word_n, upper_n, wide_n, abort_n, end_n, ready_n, irq_n, rnw, window_n, cap_hit;
    logic [7:0] reg_addr, cache;
    logic [31:0] reg_wdata, reg_rdata;
    logic [5:0] eng_status_set, st, stat_mirror;
    logic [3:0] eng_upper_be_n, be_n, pbe, lat_cmd;
    logic [1:0] req_mode;
    logic [9:0] cmd_mirror;
    pclsb_pkg::pclsb_master_s eng_master, pm;
    pclsb_pkg::pclsb_target_s eng_target;
    pclsb_pkg::pclsb_term_s eng_term;
    int bad_count, num_checks, cycles, n;
    int shadow[$];
    pclsb_local_if uut (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq, .eng_master, .eng_target, .eng_status_set, .eng_term,
        .eng_upper_be_n, .inta_out, .inta_oe, .master_byte_lane_enables_n(be_n),
        .master_word_strobe_n(word_n), .master_upper_dword_strobe_n(upper_n),
        .master_wide_transfer_n(wide_n), .local_irq_n(irq_n), .cache_line_size(cache),
        .command_mirror(cmd_mirror), .status_mirror(stat_mirror),
        .target_abort_request_n(abort_n), .target_early_end_request_n(end_n),
        .target_ready_n(ready_n), .target_read_not_write(rnw),
        .target_access_window_n(window_n), .target_latched_bus_command(lat_cmd),
        .extended_cap_hit(cap_hit));
    pclsb_backend u_backend (.core_clk, .reset_n, .target_access_window_n(window_n),
        .master_upper_dword_strobe_n(upper_n), .slow, .req_mode, .irq_req,
        .master_byte_lane_enables_n(be_n), .local_irq_n(irq_n),
        .target_abort_request_n(abort_n), .target_early_end_request_n(end_n),
        .target_ready_n(ready_n));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic test_done;
        if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // A hung handshake ends the run as a failure.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    initial begin
        {reset_n, reg_wr, reg_rd, slow, irq_req, req_mode, reg_addr, reg_wdata} = '0;
        eng_master = '0;
        eng_target = '0;
        eng_status_set = '0;
        n = $urandom(32'hD373C199);
        repeat (10) @(posedge core_clk);
        chk(word_n & upper_n & wide_n & window_n, 1);
        reset_n <= 1'b1;
        for (int a = 0; a < 6; a++) rd(8'(4 * a), 0);
        shadow.push_back($urandom & 32'h7FF);
        shadow.push_back($urandom & 32'hFF);
        wr(8'h00, shadow[0]);
        wr(8'h08, shadow[1]);
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h00, shadow[0] & 32'h77F);
        rd(8'h08, shadow[1]);
        rd(8'h20, 0);
        chk(cmd_mirror, shadow[0] & 32'h37F);
        chk(cache, shadow[1]);
        st = 6'($urandom) | 6'h01;
        @(posedge core_clk);
        eng_status_set <= st;
        @(posedge core_clk);
        eng_status_set <= 6'h00;
        rd(8'h04, st);
        chk(stat_mirror, st);
        wr(8'h04, {26'h0, st});
        rd(8'h04, 0);
        for (int w = 1; w >= 0; w--) begin
            wr(8'h0C, w);
            for (int i = 0; i < 30; i++) begin
                @(posedge core_clk);
                eng_master <= pclsb_pkg::pclsb_master_s'(2'($urandom));
                #1;
                if (i > 0) begin
                    chk(word_n, !pm.data_xfer);
                    chk(upper_n, !(pm.data_xfer && pm.wide_trans && w));
                    chk(wide_n, !pm.wide_trans);
                    chk(eng_upper_be_n, w ? pbe : 4'hF);
                end
                pm = eng_master;
                pbe = be_n;
            end
        end
        for (int c = 0; c < 16; c++) begin
            @(posedge core_clk);
            eng_master <= '0;
            eng_target.start <= 1'b1;
            eng_target.bus_cmd <= 4'(c);
            eng_target.active <= 1'b1;
            eng_target.exprom_hit <= (c == 9);
            eng_target.bar_hit <= (c > 11) ? 6'h20 : 6'h00;
            @(posedge core_clk);
            eng_target.start <= 1'b0;
            @(posedge core_clk);
            eng_target.active <= 1'b0;
            #1 chk(lat_cmd, c);
            chk(rnw, !c[0]);
            chk(window_n, !(c == 1 || c == 9 || c > 11));
        end
        eng_target.exprom_hit <= 1'b0;
        wr(8'h14, 32'hF);
        for (int k = 0; k < 3; k++) begin
            shadow.push_back(k == 0 ? 4 : (k == 1 ? 2 : 1));
            @(posedge core_clk);
            req_mode <= (k == 0) ? 2'h2 : 2'h1;
            slow <= 1'($urandom);
            eng_target.start <= 1'b1;
            eng_target.bus_cmd <= 4'h6;
            eng_target.active <= 1'b1;
            eng_target.bar_hit <= 6'h01;
            @(posedge core_clk);
            eng_target.start <= 1'b0;
            eng_target.data_xfer <= (k == 1);
            @(posedge core_clk);
            eng_target.data_xfer <= 1'b0;
            n = 0;
            while (!(eng_term.abort || eng_term.disconnect || eng_term.retry) && n < 20) begin
                @(posedge core_clk);
                #1 n++;
            end
            chk({eng_term.abort, eng_term.disconnect, eng_term.retry}, shadow[2 + k]);
            chk(eng_term.ready, !slow);
            @(posedge core_clk);
            eng_target.active <= 1'b0;
            req_mode <= 2'h0;
            repeat (4) @(posedge core_clk);
            rd(8'h10, 2 << k);
            chk(irq, 1);
            wr(8'h10, 32'hF);
            #1 chk(irq, 0);
        end
        for (int e = 0; e < 2; e++) begin
            wr(8'h00, e ? 32'h000 : 32'h400);
            irq_req <= 1'b1;
            repeat (8) @(posedge core_clk);
            #1 chk(inta_oe, e);
            chk(inta_out, 0);
            @(posedge core_clk);
            irq_req <= 1'b0;
            repeat (8) @(posedge core_clk);
            #1 chk(inta_oe, 0);
        end
        rd(8'h10, 1);
        for (int j = 0; j < 3; j++) begin
            @(posedge core_clk);
            eng_target.cfg_access <= 1'b1;
            eng_target.cfg_offset <= 8'(63 + 96 * j);
            @(posedge core_clk);
            eng_target.cfg_access <= 1'b0;
            #1 chk(cap_hit, j > 0);
        end
        test_done();
    end
endmodule // pclsb_local_if_bench
`default_nettype wire
